// [verilog/fsp_pkg.sv]
// Constants, register layout and types for the flash self-program sequencer.
// Assumes a 200 MHz system clock; imported by the sequencer and the bench, not by the buffer or its interface.
package fsp_pkg;
	// Register map (one 32-bit word each, data in the low 16 bits at most)
	localparam logic [3:0] CTRL_OFFSET     = 4'h0;
	localparam logic [3:0] POINTER_OFFSET  = 4'h4;
	localparam logic [3:0] DATA_OFFSET     = 4'h8;
	localparam logic [3:0] STROBE_OFFSET   = 4'hC;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	// Control bit positions
	localparam int         BIT_RDY_IE      = 7;
	localparam int         BIT_BUSY        = 6;
	localparam int         BIT_SECT_RE     = 4;
	localparam int         BIT_LOCK_SEL    = 3;
	localparam int         BIT_PG_WRITE    = 2;
	localparam int         BIT_PG_ERASE    = 1;
	localparam int         BIT_PROG_EN     = 0;
	// Accepted command patterns in the low five bits
	localparam logic [4:0] CMD_SECT_RE     = 5'h11;
	localparam logic [4:0] CMD_LOCK_READ   = 5'h09;
	localparam logic [4:0] CMD_PG_WRITE    = 5'h05;
	localparam logic [4:0] CMD_PG_ERASE    = 5'h03;
	localparam logic [4:0] CMD_LOAD        = 5'h01;
	// Strobe register bits
	localparam int         STB_STORE       = 0;
	localparam int         STB_EEPROM_WR   = 1;
	localparam int         STB_GLOBAL_IE   = 2;
	// Timing
	localparam int         ARM_WINDOW_CYC  = 4;
	localparam int         CLK_MHZ         = 200;
	localparam int         PROG_TIME_US    = 4500;
	localparam int         PROG_CYC        = PROG_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {
		FSP_IDLE  = 2'b00,
		FSP_ARMED = 2'b01,
		FSP_BUSY  = 2'b11
	} fsp_state_t;
endpackage : fsp_pkg

// [verilog/fsp_buf_if.sv]
// Carrier between sequencer and page buffer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface fsp_buf_if #(parameter int WORD_BITS = 5);
	logic                 clear;
	logic                 load;
	logic [WORD_BITS-1:0] word_addr;
	logic [15:0]          load_data;
	logic [WORD_BITS-1:0] read_addr;
	logic [15:0]          read_data;
	modport seq (output clear, output load, output word_addr, output load_data,
		output read_addr, input read_data);
	modport buffer (input clear, input load, input word_addr, input load_data,
		input read_addr, output read_data);
endinterface : fsp_buf_if
`default_nettype wire

// [verilog/fsp_page_buffer.sv]
// Temporary page buffer with per-word valid bits.
// Assumes a synchronous clear and one load per cycle.
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer #(
	parameter int WORD_BITS = 5
) (
	// System
	input  wire logic clock,
	input  wire logic reset_n,
	// Sequencer side
	fsp_buf_if.buffer bus
);
	localparam int WORDS = 1 << WORD_BITS;
	logic [15:0]      mem [WORDS];
	logic [WORDS-1:0] valid;

	// Unloaded words read as erased flash; a load in the clearing cycle survives
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			valid <= '0;
		end else begin
			if (bus.clear) begin
				valid <= '0;
			end
			if (bus.load) begin
				valid[bus.word_addr] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (bus.load) begin
			mem[bus.word_addr] <= bus.load_data;
		end
	end

	assign bus.read_data = valid[bus.read_addr] ? mem[bus.read_addr] : 16'hFFFF;
endmodule : fsp_page_buffer
`default_nettype wire

// [verilog/fsp_sequencer.sv]
// Flash self-program sequencer: control register, arming window, buffer and flash port.
// Assumes the core's store-program strobe and EEPROM activity arrive as register writes.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: Code 00000011 then store within four cycles erases the addressed page.
// RQ2: Erase uses only the page field of the pointer.
// RQ3: Core stall holds for the whole erase.
// RQ4: Code 00000001 then store within four cycles loads one buffer word.
// RQ5: Buffer word chosen by the word field of the pointer.
// RQ6: Buffer cleared after page write, section read enable, and reset.
// RQ7: Software loads each buffer word at most once between clears.
// RQ8: EEPROM write during page loading discards the buffer.
// RQ9: Code 00000101 then store within four cycles writes buffer to page.
// RQ10: Software zeroes pointer bits outside the page field for writes.
// RQ11: Core stall holds for the whole page write.
// RQ12: Software erases a page before writing it.
// RQ13: Software uses the same page number for erase and write.
// RQ14: Buffer loads accepted in any word order.
// RQ15: Store accepted regardless of fetch address; no boot section.
// RQ16: Address low bits pick word in page, high bits pick page.
// RQ17: Byte reads use pointer bit zero as byte select.
// RQ18: Enable clears after store or four idle cycles; stays during erase/write.
// RQ19: Other low-five-bit patterns are ignored.
// RQ20: EEPROM write in progress blocks programming and lock reads.
// RQ21: Ready interrupt requested while enables set and programming enable clear.
// RQ22: Duration counter holds stall and enable until expiry.
module fsp_sequencer
	import fsp_pkg::*;
#(
	parameter int WORD_BITS = 5,
	parameter int PAGE_BITS = 7,
	parameter int PROG_CYCLES = PROG_CYC
) (
	// System
	input  wire logic                           clock,
	input  wire logic                           reset_n,
	// Avalon-MM slave
	input  wire logic [3:0]                     avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [31:0]                    avs_writedata,
	output logic      [31:0]                    avs_readdata,
	output logic                                avs_waitrequest,
	// Core status
	input  wire logic                           eeprom_busy,
	output logic                                core_stall,
	output logic                                ready_irq,
	// Flash array
	output logic                                flash_erase,
	output logic                                flash_write,
	output logic      [PAGE_BITS-1:0]           flash_page,
	output logic      [15:0]                    flash_wdata,
	output logic      [WORD_BITS-1:0]           flash_word,
	output logic      [PAGE_BITS+WORD_BITS:0]   read_byte_addr
);
	localparam int PTR_BITS = PAGE_BITS + WORD_BITS + 1;

	fsp_state_t           state;
	logic [7:0]           ctrl;
	logic [15:0]          pointer;
	logic [15:0]          data_pair;
	logic [2:0]           arm_cnt;
	logic [31:0]          dur_cnt;
	logic                 global_ie;
	logic                 loading;
	logic                 ack;
	logic                 wr_ctrl;
	logic                 wr_strobe;
	logic                 store;
	logic                 eeprom_wr;

	fsp_buf_if #(.WORD_BITS(WORD_BITS)) buf_bus ();

	fsp_page_buffer #(.WORD_BITS(WORD_BITS)) fsp_page_buffer_inst (
		.clock   (clock),
		.reset_n (reset_n),
		.bus     (buf_bus)
	);

	function automatic logic cmd_legal(input logic [4:0] c);
		return c == CMD_SECT_RE || c == CMD_LOCK_READ || c == CMD_PG_WRITE
			|| c == CMD_PG_ERASE || c == CMD_LOAD;
	endfunction : cmd_legal

	function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] p);
		return p[WORD_BITS+PAGE_BITS:WORD_BITS+1];
	endfunction : page_of

	// One wait state: every access answers at the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign wr_ctrl   = avs_write && ack && avs_address == CTRL_OFFSET;
	assign wr_strobe = avs_write && ack && avs_address == STROBE_OFFSET;
	assign store     = wr_strobe && avs_writedata[STB_STORE];
	assign eeprom_wr = wr_strobe && avs_writedata[STB_EEPROM_WR];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			avs_readdata <= '0;
		end else if (avs_read && !ack) begin
			case (avs_address)
				CTRL_OFFSET:    avs_readdata <= {24'h0000_00, ctrl};
				POINTER_OFFSET: avs_readdata <= {16'h0000, pointer};
				DATA_OFFSET:    avs_readdata <= {16'h0000, data_pair};
				STROBE_OFFSET:  avs_readdata <= {29'h0000_0000, global_ie, eeprom_busy,
					state == FSP_BUSY};
				default:        avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pointer   <= 16'h0000;
			data_pair <= 16'h0000;
			global_ie <= 1'b0;
		end else if (avs_write && ack) begin
			if (avs_address == POINTER_OFFSET) begin
				pointer <= avs_writedata[15:0];
			end
			if (avs_address == DATA_OFFSET) begin
				data_pair <= avs_writedata[15:0];
			end
			if (avs_address == STROBE_OFFSET) begin
				global_ie <= avs_writedata[STB_GLOBAL_IE];
			end
		end
	end

	// Sequencer; store accepted from any fetch address // see RQ15
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state   <= FSP_IDLE;
			ctrl    <= CTRL_RESET;
			arm_cnt <= '0;
			dur_cnt <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl[BIT_RDY_IE] <= avs_writedata[BIT_RDY_IE];
			end
			case (state)
				FSP_IDLE: begin
					// Blocked while EEPROM busy // see RQ20
					if (wr_ctrl && cmd_legal(avs_writedata[4:0]) && !eeprom_busy) begin // see RQ19
						ctrl[4:0] <= avs_writedata[4:0];
						arm_cnt   <= 3'(ARM_WINDOW_CYC);
						state     <= FSP_ARMED;
					end
				end
				FSP_ARMED: begin
					if (store && ctrl[4:0] inside {CMD_PG_ERASE, CMD_PG_WRITE}) begin // see RQ1, RQ9
						dur_cnt <= 32'(PROG_CYCLES); // see RQ22
						state   <= FSP_BUSY;
					end else if (store || arm_cnt == 3'd1) begin
						ctrl[4:0] <= 5'h00; // see RQ18
						state     <= FSP_IDLE;
					end else begin
						arm_cnt <= arm_cnt - 3'd1;
					end
				end
				FSP_BUSY: begin
					if (dur_cnt <= 32'd1) begin
						ctrl[4:0] <= 5'h00; // see RQ18
						state     <= FSP_IDLE;
					end else begin
						dur_cnt <= dur_cnt - 32'd1;
					end
				end
				default: state <= FSP_IDLE;
			endcase
		end
	end

	// Stall covers the full erase or write // see RQ3, RQ11, RQ22
	assign core_stall = state == FSP_BUSY;
	assign ready_irq  = ctrl[BIT_RDY_IE] && global_ie && !ctrl[BIT_PROG_EN]; // see RQ21

	// Loading phase spans first load to the next clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			loading <= 1'b0;
		end else if (buf_bus.load) begin
			loading <= 1'b1;
		end else if (buf_bus.clear) begin
			loading <= 1'b0;
		end
	end

	// Arbitrary word order accepted // see RQ14
	assign buf_bus.load = state == FSP_ARMED && store && ctrl[4:0] == CMD_LOAD; // see RQ4
	assign buf_bus.word_addr = pointer[WORD_BITS:1]; // see RQ5, RQ16
	assign buf_bus.load_data = data_pair;
	// Read one word ahead so address and data leave the flops together
	assign buf_bus.read_addr = (state == FSP_BUSY) ? WORD_BITS'(flash_word + 1'b1) : '0;
	// see RQ6, RQ8
	assign buf_bus.clear = (state == FSP_BUSY && dur_cnt <= 32'd1 && ctrl[BIT_PG_WRITE])
		|| (state == FSP_ARMED && ctrl[4:0] == CMD_SECT_RE)
		|| (eeprom_wr && loading);

	// Flash array strobes and addresses
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			flash_erase <= 1'b0;
			flash_write <= 1'b0;
			flash_page  <= '0;
			flash_word  <= '0;
			flash_wdata <= '0;
		end else begin
			flash_erase <= state == FSP_ARMED && store && ctrl[4:0] == CMD_PG_ERASE;
			flash_write <= state == FSP_ARMED && store && ctrl[4:0] == CMD_PG_WRITE;
			if (state == FSP_ARMED && store) begin
				flash_page  <= page_of(pointer); // see RQ2, RQ16
				flash_word  <= '0;
				flash_wdata <= buf_bus.read_data;
			end else if (state == FSP_BUSY && ctrl[BIT_PG_WRITE]) begin
				flash_word  <= flash_word + 1'b1;
				flash_wdata <= buf_bus.read_data;
			end
		end
	end

	// Byte address includes pointer bit zero // see RQ17
	assign read_byte_addr = pointer[PTR_BITS-1:0];
endmodule : fsp_sequencer
`default_nettype wire

// [dv/fsp_chk.sv]
// Port checker for the sequencer.
// Assumes one clock; the bind passes PROG_CYCLES down.
`timescale 1ns/1ps
`default_nettype none
module fsp_chk #(
	parameter int PROG_CYCLES = 20
) (
	// System
	input wire logic clock,
	input wire logic reset_n,
	// Bus and core
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic core_stall,
	// Flash
	input wire logic flash_erase,
	input wire logic flash_write
);
	int stall_len;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		avs_read || avs_write;
	endsequence
	sequence s_pulse;
		flash_erase || flash_write;
	endsequence
	always_ff @(posedge clock) begin
		if (!reset_n || !core_stall)
			stall_len <= 0;
		else
			stall_len <= stall_len + 1;
	end
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("request answered without wait state");
	a_wait_done: assert property (s_req ##0 avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in two cycles");
	a_erase_stalls: assert property (flash_erase |-> ##[0:1] core_stall)
		else $error("erase without stall");
	a_write_stalls: assert property (flash_write |-> ##[0:1] core_stall)
		else $error("page write without stall");
	a_pulse_single: assert property (s_pulse |=> !flash_erase && !flash_write)
		else $error("flash pulse longer than one cycle");
	a_pulse_excl: assert property (!(flash_erase && flash_write))
		else $error("erase and write together");
	a_busy_no_pulse: assert property ($past(core_stall, 2) && core_stall |-> !(flash_erase || flash_write))
		else $error("new operation during busy");
	a_stall_length: assert property ($fell(core_stall) |-> stall_len >= PROG_CYCLES - 1
		&& stall_len <= PROG_CYCLES + 1)
		else $error("stall length off");
	a_stall_bound: assert property (stall_len <= PROG_CYCLES + 1)
		else $error("stall never ends");
endmodule : fsp_chk
bind fsp_sequencer fsp_chk #(.PROG_CYCLES(PROG_CYCLES)) fsp_chk_inst (.clock(clock),
	.reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .core_stall(core_stall),
	.flash_erase(flash_erase), .flash_write(flash_write));
`default_nettype wire

// [dv/fsp_flash_model.sv]
// Behavioural flash array behind the sequencer.
// Assumes write data steps through words while the core is stalled.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
	// System
	input wire logic        clock,
	// Flash port
	input wire logic        core_stall,
	input wire logic        flash_erase,
	input wire logic        flash_write,
	input wire logic [6:0]  flash_page,
	input wire logic [15:0] flash_wdata,
	input wire logic [4:0]  flash_word
);
	logic [15:0] mem [128][32];
	logic        writing = 1'b0;
	logic [6:0]  page;
	int          pulses = 0;
	always @(posedge clock) begin
		if (flash_erase || flash_write)
			pulses <= pulses + 1;
		if (flash_erase)
			for (int i = 0; i < 32; i++)
				mem[flash_page][i] <= 16'hFFFF;
		if (flash_write) begin
			writing <= 1'b1;
			page <= flash_page;
		end else if (!core_stall)
			writing <= 1'b0;
		if ((writing || flash_write) && core_stall)
			mem[flash_write ? flash_page : page][flash_word] <= flash_wdata;
	end
endmodule : fsp_flash_model
`default_nettype wire

// [dv/flash_self_program_sequencer_bench.sv]
// Self-checking bench: bus master, flash model, random page programming.
// Assumes a short PROG_CYCLES to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_bench;
	import fsp_pkg::*;
	logic        clock, reset_n, avs_read, avs_write, eeprom_busy, gie;
	logic        avs_waitrequest, core_stall, ready_irq, flash_erase, flash_write;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [6:0]  flash_page, pg;
	logic [15:0] flash_wdata, exp_pg [32], d;
	logic [4:0]  flash_word, w;
	logic [12:0] read_byte_addr;
	int          num_errors, tests_run, p0;
	fsp_sequencer #(.PROG_CYCLES(40)) fsp_sequencer_inst (.clock(clock), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eeprom_busy(eeprom_busy),
		.core_stall(core_stall), .ready_irq(ready_irq), .flash_erase(flash_erase),
		.flash_write(flash_write), .flash_page(flash_page), .flash_wdata(flash_wdata),
		.flash_word(flash_word), .read_byte_addr(read_byte_addr));
	fsp_flash_model fsp_flash_model_inst (.clock(clock), .core_stall(core_stall),
		.flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
		.flash_wdata(flash_wdata), .flash_word(flash_word));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	function automatic logic [31:0] exp_byte_addr(input logic [15:0] p);
		return {19'h0_0000, p[12:0]};
	endfunction : exp_byte_addr
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dt);
		@(posedge clock);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= dt;
		// No local limit: a hung slave is caught by the watchdog
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic store(input logic [1:0] s);
		bus(1'b1, STROBE_OFFSET, {29'h0000_0000, gie, s});
	endtask : store
	task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] dt);
		bus(1'b1, POINTER_OFFSET, {16'h0000, p});
		bus(1'b1, DATA_OFFSET, {16'h0000, dt});
		// Pointer has settled by now; sampling at its own write edge would race
		chk("byte addr", exp_byte_addr(p), {19'h0_0000, read_byte_addr});
		bus(1'b1, CTRL_OFFSET, {24'h00_0000, c});
		store(2'b01);
		repeat (3) @(posedge clock);
		while (core_stall !== 1'b0) begin
			@(posedge clock);
		end
	endtask : cmd
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test();
	end
	initial begin
		{reset_n, avs_read, avs_write, eeprom_busy, gie} = 5'h00;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		num_errors = 0;
		tests_run = 0;
		void'($urandom(97428));
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		chk("ctrl reset", 32'h0000_0000, rd);
		bus(1'b0, 4'h2, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		$display("reset test done");
		// Scattered loads, erase with junk low bits, then write with them clear
		pg = 7'($urandom);
		p0 = $urandom;
		for (int i = 0; i < 32; i++)
			exp_pg[i] = 16'hFFFF;
		for (int k = 0; k < 8; k++) begin
			w = 5'((k * 13 + p0) % 32);
			d = 16'($urandom);
			exp_pg[w] = d;
			cmd(8'h01, {3'b000, pg, w, 1'($urandom)}, d);
		end
		p0 = fsp_flash_model_inst.pulses;
		cmd(8'h03, {3'b111, pg, 6'h2B}, 16'($urandom));
		chk("erased", 32'h0000_FFFF, {16'h0000, fsp_flash_model_inst.mem[pg][0]});
		cmd(8'h05, {3'b000, pg, 6'h00}, 16'($urandom));
		chk("pulses", p0 + 2, fsp_flash_model_inst.pulses);
		for (int i = 0; i < 32; i++)
			chk("page word", {16'h0000, exp_pg[i]}, {16'h0000, fsp_flash_model_inst.mem[pg][i]});
		$display("program test done");
		// Late store, bad pattern and EEPROM busy must all be ignored
		p0 = fsp_flash_model_inst.pulses;
		bus(1'b1, CTRL_OFFSET, 32'h0000_0005);
		repeat (6) @(posedge clock);
		store(2'b01);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0007);
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		chk("bad pattern", 32'h0000_0000, {27'h000_0000, rd[4:0]});
		eeprom_busy <= 1'b1;
		bus(1'b1, CTRL_OFFSET, 32'h0000_0003);
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		chk("eeprom block", 32'h0000_0000, {27'h000_0000, rd[4:0]});
		eeprom_busy <= 1'b0;
		chk("late store", p0, fsp_flash_model_inst.pulses);
		// Buffer cleared by EEPROM write and by section read enable
		for (int m = 0; m < 2; m++) begin
			pg = 7'($urandom);
			cmd(8'h01, {3'b000, pg, 6'h06}, 16'h1234);
			if (m == 0)
				store(2'b10);
			else
				cmd(8'h11, 16'h0000, 16'h0000);
			cmd(8'h03, {3'b000, pg, 6'h00}, 16'h0000);
			cmd(8'h05, {3'b000, pg, 6'h00}, 16'h0000);
			chk("cleared", 32'h0000_FFFF, {16'h0000, fsp_flash_model_inst.mem[pg][3]});
		end
		$display("clear test done");
		gie = 1'b1;
		bus(1'b1, CTRL_OFFSET, 32'h0000_0080);
		store(2'b00);
		@(posedge clock);
		chk("irq idle", 32'h0000_0001, {31'h0000_0000, ready_irq});
		bus(1'b1, CTRL_OFFSET, 32'h0000_0081);
		@(posedge clock);
		chk("irq armed", 32'h0000_0000, {31'h0000_0000, ready_irq});
		repeat (6) @(posedge clock);
		chk("irq expired", 32'h0000_0001, {31'h0000_0000, ready_irq});
		bus(1'b0, STROBE_OFFSET, 32'h0000_0000);
		chk("strobe status", 32'h0000_0004, rd);
		$display("irq test done");
		stop_test();
	end
endmodule : flash_self_program_sequencer_bench
`default_nettype wire
